// ### sim/aux_pin_observer.sv
// bench observer resolving the auxiliary pin wires
`timescale 1ns/1ps
module aux_pin_observer
(
  input  wire logic pin_one_i,
  input  wire logic oe_one_i,
  input  wire logic pin_two_i,
  input  wire logic oe_two_i,
  output logic      level_one_o,
  output logic      level_two_o
);
  // released pins settle low through the pull-down
  assign level_one_o = oe_one_i ? pin_one_i : 1'b0;
  assign level_two_o = oe_two_i ? pin_two_i : 1'b0;
endmodule

// ### sim/test_aux_test_signal_mux_prbs.sv
// self-checking bench for the aux test mux and prbs framer
`timescale 1ns/1ps
`include "aux_test_defs.svh"
module test_aux_test_signal_mux_prbs
  import aux_test_pkg::*;
;
  logic                 mclk_i = 1'b0;
  logic                 rst_n_i = 1'b0;
  analog_test_control_t atc = '0;
  logic           [7:0] d1 = 8'h00;
  logic           [7:0] d2 = 8'h00;
  aux_sources_t         src = '0;
  prbs_config_t         cfg = '0;
  logic                 send = 1'b0;
  logic                 p1, oe1, p2, oe2, en1, en2, lv1, lv2, tb, tv;
  logic           [7:0] c1, c2;
  logic          [21:0] mq[$];
  logic                 fq[$];
  logic                 dq[$];
  integer               seed, mismatches, n_tests;

  always #2.5 mclk_i = ~mclk_i;

  aux_test_signal_mux_prbs u_aux_test_signal_mux_prbs (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .analog_test_control_i(atc),
    .test_dac_value_one_i(d1), .test_dac_value_two_i(d2),
    .sources_i(src), .prbs_cfg_i(cfg), .send_cmd_i(send),
    .auxiliary_pin_one_o(p1), .auxiliary_pin_one_oe_o(oe1),
    .auxiliary_pin_two_o(p2), .auxiliary_pin_two_oe_o(oe2),
    .dac_one_en_o(en1), .dac_one_code_o(c1), .dac_two_en_o(en2),
    .dac_two_code_o(c2), .prbs_tx_bit_o(tb), .prbs_tx_valid_o(tv));

  aux_pin_observer u_aux_pin_observer (
    .pin_one_i(p1), .oe_one_i(oe1), .pin_two_i(p2), .oe_two_i(oe2),
    .level_one_o(lv1), .level_two_o(lv2));

  // ----------------------------------------
  // expectations and reporting
  // ----------------------------------------
  function automatic logic [10:0] exp_f(input logic [3:0] s,
                                        input logic [7:0] d,
                                        input aux_sources_t x);
    logic [7:0] c;
    logic       p;
    c = 8'h00;
    p = 1'b0;
    case (s)
      4'h1: c = d;
      4'h2: c = {8{x.correlator_one_signal}};
      4'h3: c = {8{x.correlator_two_signal}};
      4'h4: c = {8{x.minimum_level_signal}};
      4'h5: c = {8{x.adc_i_sample}};
      4'h6: c = {8{x.adc_q_sample}};
      4'h7: c = {{4{x.adc_i_sample}}, {4{x.adc_q_sample}}};
      4'h8: p = x.prod_test_signal;
      4'h9: p = x.sam_clock;
      4'hA: p = 1'b1;
      4'hC: p = x.transmit_active;
      4'hD: p = x.receive_active;
      4'hE: p = x.subcarrier_detected;
      4'hF: p = x.test_bus_bit;
      default: p = 1'b0;
    endcase
    return {s[3], (s != 4'h0) && !s[3], c, p};
  endfunction

  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // output monitor
  // ----------------------------------------
  always @(negedge mclk_i)
  begin
    if (mq.size() > 0)
      check(mq.pop_front() === {oe1, en1, c1, lv1, oe2, en2, c2, lv2},
            "pin mux");
    if (tv === 1'b1 && fq.size() > 0)
      check(tb === fq.pop_front(), "framing bit");
    else if (tv === 1'b1)
      dq.push_back(tb);
  end

  // ----------------------------------------
  // prbs run
  // ----------------------------------------
  task automatic run(input logic p15, input logic [3:0] pre,
                     input logic sy, input logic st, input logic pa);
    int   k, e1, e2, len;
    logic px;
    logic b[$];
    @(posedge mclk_i);
    send <= 1'b1;
    @(posedge mclk_i);
    send <= 1'b0;
    cfg <= {1'b0, p15, pre, sy, st, pa};
    for (k = 0; k < pre * 8; k++) fq.push_back(1'b0);
    if (sy) for (k = 7; k >= 0; k--) fq.push_back(1'(`SYNC_BYTE >> k));
    if (st) fq.push_back(1'b0);
    @(posedge mclk_i);
    cfg.prbs_enable <= 1'b1;
    repeat (4) @(negedge mclk_i);
    check(tv === 1'b0, "start without send");
    @(posedge mclk_i);
    send <= 1'b1;
    k = 0;
    while (tv !== 1'b1 && k < 8)
    begin
      @(negedge mclk_i);
      k++;
    end
    @(posedge mclk_i);
    send <= 1'b0;
    check(k < 8, "valid after send");
    if (k == 8)
    begin
      fq.delete();
      return;
    end
    repeat (fq.size() + 300) @(negedge mclk_i);
    check(fq.size() == 0 && dq.size() > 290, "stream stands");
    @(posedge mclk_i);
    cfg.prbs_enable <= 1'b0;
    repeat (4) @(negedge mclk_i);
    check(tv === 1'b0, "stream stops");
    for (k = 0; k < dq.size(); k++)
      if (!pa || k % 9 != 8) b.push_back(dq[k]);
    px = 1'b0;
    for (k = 0; pa && k < dq.size() - dq.size() % 9; k++)
    begin
      px = px ^ dq[k];
      if (k % 9 == 8)
      begin
        check(px === 1'b1, "odd parity");
        px = 1'b0;
      end
    end
    len = p15 ? 15 : 9;
    e1 = 0;
    e2 = 0;
    for (k = len; k < b.size(); k++)
    begin
      e1 += (b[k] !== (b[k-len] ^ b[k-(p15 ? 1 : 4)]));
      e2 += (b[k] !== (b[k-len] ^ b[k-(p15 ? 14 : 5)]));
    end
    check((e1 == 0 || e2 == 0) && b.size() > 200, "sequence");
    dq.delete();
    $display("prbs run len %0d done", len);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'h19A6;
    mismatches = 0;
    n_tests = 0;
    @(negedge mclk_i);
    check({p1, oe1, p2, oe2, en1, en2, c1, c2, tb, tv} === '0,
          "reset values");
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge mclk_i);
      atc <= {i[3:0], ~i[3:0]};
      src <= 11'($random(seed));
      d1 <= 8'($random(seed));
      d2 <= 8'($random(seed));
      @(posedge mclk_i);
      mq.push_back({exp_f(i[3:0], d1, src), exp_f(~i[3:0], d2, src)});
    end
    @(negedge mclk_i);
    $display("mux sweep done");
    run(1'b0, 4'h1 + 4'($unsigned($random(seed)) % 3), 1'b1, 1'b1, 1'b1);
    if (mismatches == 0)
      run(1'b1, 4'h0, 1'b0, 1'b0, 1'b0);
    complete_run();
  end
endmodule

// ### src/aux_pin_mux.sv
// one auxiliary pin source selector
`timescale 1ns/1ps
`include "aux_test_defs.svh"
module aux_pin_mux
  import aux_test_pkg::*;
(
  input  wire logic         [3:0] sel_i,
  input  wire logic         [7:0] dac_reg_i,
  input  wire aux_sources_t       src_i,
  output logic                    pin_o,
  output logic                    pin_oe_o,
  output logic                    dac_en_o,
  output logic              [7:0] dac_code_o
);
  logic [7:0] dac_v;

  always_comb
  begin
    pin_o    = 1'b0;
    pin_oe_o = 1'b1;
    dac_en_o = (sel_i >= `SEL_DAC_REG) && (sel_i <= `SEL_ADC_IQ);
    dac_v    = 8'h00;
    case (sel_i)
      `SEL_TRISTATE:   pin_oe_o = 1'b0;
      `SEL_DAC_REG:    dac_v = dac_reg_i;
      `SEL_CORR_ONE:   dac_v = {8{src_i.correlator_one_signal}};
      `SEL_CORR_TWO:   dac_v = {8{src_i.correlator_two_signal}};
      `SEL_MIN_LEVEL:  dac_v = {8{src_i.minimum_level_signal}};
      `SEL_ADC_I:      dac_v = {8{src_i.adc_i_sample}};
      `SEL_ADC_Q:      dac_v = {8{src_i.adc_q_sample}};
      `SEL_ADC_IQ:     dac_v = {{4{src_i.adc_i_sample}},
                                {4{src_i.adc_q_sample}}};
      `SEL_PROD_TEST:  pin_o = src_i.prod_test_signal;
      `SEL_SAM_CLK:    pin_o = src_i.sam_clock;
      `SEL_HIGH:       pin_o = 1'b1;
      `SEL_LOW:        pin_o = 1'b0;
      `SEL_TX_ACTIVE:  pin_o = src_i.transmit_active;
      `SEL_RX_ACTIVE:  pin_o = src_i.receive_active;
      `SEL_SUBCARRIER: pin_o = src_i.subcarrier_detected;
      `SEL_TEST_BUS:   pin_o = src_i.test_bus_bit;
      default:         pin_oe_o = 1'b0;
    endcase
    if (dac_en_o)
    begin
      pin_oe_o = 1'b0;
    end
  end

  assign dac_code_o = dac_v;
endmodule

// ### src/aux_test_defs.svh
// constants for the auxiliary test-signal mux and prbs framer
`ifndef AUX_TEST_DEFS_SVH
`define AUX_TEST_DEFS_SVH
`define SEL_TRISTATE   4'h0
`define SEL_DAC_REG    4'h1
`define SEL_CORR_ONE   4'h2
`define SEL_CORR_TWO   4'h3
`define SEL_MIN_LEVEL  4'h4
`define SEL_ADC_I      4'h5
`define SEL_ADC_Q      4'h6
`define SEL_ADC_IQ     4'h7
`define SEL_PROD_TEST  4'h8
`define SEL_SAM_CLK    4'h9
`define SEL_HIGH       4'hA
`define SEL_LOW        4'hB
`define SEL_TX_ACTIVE  4'hC
`define SEL_RX_ACTIVE  4'hD
`define SEL_SUBCARRIER 4'hE
`define SEL_TEST_BUS   4'hF
`define PRBS9_LEN      4'h9
`define PRBS15_LEN     4'hF
`define PRBS_SEED      15'h7FFF
`define SYNC_BYTE      8'hB2
`endif

// ### src/aux_test_pkg.sv
// types for the auxiliary test-signal mux and prbs framer
package aux_test_pkg;
  typedef struct packed {
    logic [3:0] first_pin_source_select;
    logic [3:0] second_pin_source_select;
  } analog_test_control_t;

  typedef struct packed {
    logic       correlator_one_signal;
    logic       correlator_two_signal;
    logic       minimum_level_signal;
    logic       adc_i_sample;
    logic       adc_q_sample;
    logic       prod_test_signal;
    logic       sam_clock;
    logic       transmit_active;
    logic       receive_active;
    logic       subcarrier_detected;
    logic       test_bus_bit;
  } aux_sources_t;

  typedef struct packed {
    logic       prbs_enable;
    logic       prbs15_select;
    logic [3:0] preamble_bytes;
    logic       sync_enable;
    logic       start_bit_enable;
    logic       parity_enable;
  } prbs_config_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_PREAMBLE = 3'b001,
    ST_SYNC     = 3'b010,
    ST_START    = 3'b011,
    ST_DATA     = 3'b100,
    ST_PARITY   = 3'b101
  } prbs_state_t;
endpackage

// ### src/aux_test_signal_mux_prbs.sv
// auxiliary pin test-signal routing and prbs transmit framer
`timescale 1ns/1ps
`include "aux_test_defs.svh"

// Functional notes
// - Each of the two auxiliary pins has its own 4-bit source selector.
// - Codes 0, 9 to 15 give tristate, sam clock, high, low and live signals.
// - Code 1 drives the pin's dac with its own test dac value.
// - Codes 2 to 7 drive the dac from correlators, min level and adc samples.
// - Code 8 routes the production test signal to the pin.
// - Prbs mode emits a prbs9 or prbs15 sequence as transmit data.
// - The sequence starts only once the send command is active.
// - Preamble, sync byte, start bit and parity are inserted per mode.
module aux_test_signal_mux_prbs
  import aux_test_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire analog_test_control_t analog_test_control_i,
  input  wire logic           [7:0] test_dac_value_one_i,
  input  wire logic           [7:0] test_dac_value_two_i,
  input  wire aux_sources_t         sources_i,
  input  wire prbs_config_t         prbs_cfg_i,
  input  wire logic                 send_cmd_i,
  output logic                      auxiliary_pin_one_o,
  output logic                      auxiliary_pin_one_oe_o,
  output logic                      auxiliary_pin_two_o,
  output logic                      auxiliary_pin_two_oe_o,
  output logic                      dac_one_en_o,
  output logic                [7:0] dac_one_code_o,
  output logic                      dac_two_en_o,
  output logic                [7:0] dac_two_code_o,
  output logic                      prbs_tx_bit_o,
  output logic                      prbs_tx_valid_o
);
  // ----------------------------------------------------------------
  // aux pin muxes
  // ----------------------------------------------------------------
  logic [1:0] pin_c;
  logic [1:0] oe_c;
  logic [1:0] den_c;
  logic [7:0] dcode_c [2];
  logic [3:0] sel_c   [2];
  logic [7:0] dreg_c  [2];

  assign sel_c[0]  = analog_test_control_i.first_pin_source_select;
  assign sel_c[1]  = analog_test_control_i.second_pin_source_select;
  assign dreg_c[0] = test_dac_value_one_i;
  assign dreg_c[1] = test_dac_value_two_i;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      aux_pin_mux u_mux (
        .sel_i      (sel_c[g]),
        .dac_reg_i  (dreg_c[g]),
        .src_i      (sources_i),
        .pin_o      (pin_c[g]),
        .pin_oe_o   (oe_c[g]),
        .dac_en_o   (den_c[g]),
        .dac_code_o (dcode_c[g])
      );
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      auxiliary_pin_one_o    <= 1'b0;
      auxiliary_pin_one_oe_o <= 1'b0;
      auxiliary_pin_two_o    <= 1'b0;
      auxiliary_pin_two_oe_o <= 1'b0;
      dac_one_en_o           <= 1'b0;
      dac_one_code_o         <= 8'h00;
      dac_two_en_o           <= 1'b0;
      dac_two_code_o         <= 8'h00;
    end
    else
    begin
      auxiliary_pin_one_o    <= pin_c[0];
      auxiliary_pin_one_oe_o <= oe_c[0];
      auxiliary_pin_two_o    <= pin_c[1];
      auxiliary_pin_two_oe_o <= oe_c[1];
      dac_one_en_o           <= den_c[0];
      dac_one_code_o         <= dcode_c[0];
      dac_two_en_o           <= den_c[1];
      dac_two_code_o         <= dcode_c[1];
    end
  end

  // ----------------------------------------------------------------
  // prbs framer
  // ----------------------------------------------------------------
  prbs_state_t state_q;
  prbs_state_t state_d;
  logic [14:0] lfsr_q;
  logic [3:0]  byte_cnt_q;
  logic [2:0]  bit_cnt_q;
  logic        par_q;
  logic        fb_c;
  logic        dbit_c;
  logic        run_c;
  logic [7:0]  sync_c;

  assign run_c  = prbs_cfg_i.prbs_enable;
  assign sync_c = `SYNC_BYTE;
  // prbs9: x^9+x^5+1, prbs15: x^15+x^14+1
  assign fb_c   = prbs_cfg_i.prbs15_select ?
                  (lfsr_q[14] ^ lfsr_q[13]) :
                  (lfsr_q[8] ^ lfsr_q[4]);
  assign dbit_c = prbs_cfg_i.prbs15_select ? lfsr_q[14] : lfsr_q[8];

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (run_c && send_cmd_i)
        begin
          if (prbs_cfg_i.preamble_bytes != 4'h0)
            state_d = ST_PREAMBLE;
          else if (prbs_cfg_i.sync_enable)
            state_d = ST_SYNC;
          else if (prbs_cfg_i.start_bit_enable)
            state_d = ST_START;
          else
            state_d = ST_DATA;
        end
      ST_PREAMBLE:
        if (bit_cnt_q == 3'h7 &&
            byte_cnt_q == prbs_cfg_i.preamble_bytes - 4'h1)
          state_d = prbs_cfg_i.sync_enable ? ST_SYNC :
                    (prbs_cfg_i.start_bit_enable ? ST_START : ST_DATA);
      ST_SYNC:
        if (bit_cnt_q == 3'h7)
          state_d = prbs_cfg_i.start_bit_enable ? ST_START : ST_DATA;
      ST_START:
        state_d = ST_DATA;
      ST_DATA:
        if (bit_cnt_q == 3'h7)
          state_d = prbs_cfg_i.parity_enable ? ST_PARITY : ST_DATA;
      ST_PARITY:
        state_d = ST_DATA;
      default:
        state_d = ST_IDLE;
    endcase
    if (!run_c)
      state_d = ST_IDLE;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 4'h0;
    end
    else if (state_q != state_d)
    begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 4'h0;
    end
    else if (state_q != ST_IDLE)
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7)
        byte_cnt_q <= byte_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lfsr_q <= `PRBS_SEED;
    else if (state_q == ST_IDLE)
      lfsr_q <= `PRBS_SEED;
    else if (state_q == ST_DATA)
      lfsr_q <= {lfsr_q[13:0], fb_c};
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      par_q <= 1'b1;
    else if (state_q == ST_DATA)
      par_q <= (bit_cnt_q == 3'h0) ? ~dbit_c : par_q ^ dbit_c;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prbs_tx_bit_o   <= 1'b0;
      prbs_tx_valid_o <= 1'b0;
    end
    else
    begin
      prbs_tx_valid_o <= (state_q != ST_IDLE);
      case (state_q)
        ST_PREAMBLE: prbs_tx_bit_o <= 1'b0;
        ST_SYNC:     prbs_tx_bit_o <= sync_c[3'h7 - bit_cnt_q];
        ST_START:    prbs_tx_bit_o <= 1'b0;
        ST_DATA:     prbs_tx_bit_o <= dbit_c;
        ST_PARITY:   prbs_tx_bit_o <= par_q;
        default:     prbs_tx_bit_o <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_start;
    state_q == ST_IDLE && run_c && send_cmd_i;
  endsequence

  AST_NO_SEND_NO_TX: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_q == ST_IDLE && !send_cmd_i |=> state_q == ST_IDLE)
    else $error("prbs started without send");
  AST_VALID_AFTER_SEND: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_start ##1 run_c |=> prbs_tx_valid_o)
    else $error("prbs valid missing after send");
  AST_SEL_HIGH_ONE: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_c[0] == `SEL_HIGH |=> auxiliary_pin_one_o && auxiliary_pin_one_oe_o)
    else $error("pin one not high");
  AST_TRI_TWO: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_c[1] == `SEL_TRISTATE |=> !auxiliary_pin_two_oe_o)
    else $error("pin two not tristate");
  AST_DAC_REG_ONE: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_c[0] == `SEL_DAC_REG |=> dac_one_en_o &&
      dac_one_code_o == $past(test_dac_value_one_i))
    else $error("dac one code wrong");
  AST_DAC_RANGE_TWO: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_c[1] >= `SEL_CORR_ONE && sel_c[1] <= `SEL_ADC_IQ
      |=> dac_two_en_o && !auxiliary_pin_two_oe_o)
    else $error("dac two not driven");
  AST_PROD_ONE: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_c[0] == `SEL_PROD_TEST |=>
      auxiliary_pin_one_o == $past(sources_i.prod_test_signal))
    else $error("production test not routed");
  AST_START_BIT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_q == ST_START |=> !prbs_tx_bit_o)
    else $error("start bit not low");
  AST_PRBS_SHIFT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    state_q == ST_DATA && run_c |=> lfsr_q[0] == $past(fb_c))
    else $error("lfsr did not advance");
endmodule
